// file: rtl/hbmsp_pkg.sv
// Purpose: shared constants and types of the host bus mode select port
// Assumes: 8-bit host data, 5-bit register address
// Notes: mode encoding is {type_select_hi, type_select_lo}
`default_nettype none
package hbmsp_pkg;
    localparam int HBMSP_DATA_W = 8;
    localparam int HBMSP_ADDR_W = 5;
    localparam int HBMSP_REGS = 32;
    localparam int HBMSP_SYNC_STAGES = 3;
    localparam logic [HBMSP_DATA_W-1:0] HBMSP_REG_RESET = 8'h00;
    localparam logic [1:0] HBMSP_SEL_SPLIT = 2'h0;
    localparam logic [1:0] HBMSP_SEL_FAM8 = 2'h1;
    localparam logic [1:0] HBMSP_SEL_FAM16 = 2'h2;
    localparam logic [1:0] HBMSP_SEL_RSVD = 2'h3;

    typedef enum logic [1:0] {
        HBMSP_MODE_SPLIT,
        HBMSP_MODE_FAM8,
        HBMSP_MODE_FAM16,
        HBMSP_MODE_RSVD
    } hbmsp_mode_t;
endpackage : hbmsp_pkg
`default_nettype wire

// file: rtl/hbmsp_sync.sv
// Purpose: three-flop synchroniser with agreement filter for one pin
// Assumes: pin is asynchronous to mclk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module hbmsp_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } hbmsp_sync_t;

    hbmsp_sync_t st;
    hbmsp_sync_t next_st;

    // level moves only once the second and third stages agree
    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.lvl = st.s3;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st <= {4{RESET_LEVEL}};
        end else begin
            st <= next_st;
        end
    end

    assign level = st.lvl;
endmodule : hbmsp_sync
`default_nettype wire

// file: rtl/hbmsp_port.sv
// Purpose: memory-style parallel host port with selectable bus mode
// Assumes: all host pins asynchronous to mclk; each is synchronised
// Notes: the register file is a plain 32 x 8 store; the rest of the chip
//        reads it through reg_image and raises events on irq_a_req/irq_b_req
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - both selects low: separate read/write strobes, interrupts active-high
// - strobe polarity set by selects; split mode strobe is active-low read
// - select hi=1 lo=0: single read/write line, active-low strobe, low interrupts
// - select lo=1 hi=0: 8-bit family, active-high enable strobe
// - select lo=0 hi=1: 16-bit family, same encoding as single-line low strobe
// - both family modes: single read/write line, active-low interrupts
// - eight-bit bidirectional data and five-bit address
// - internal select only when high select is 1 and low select is 0
// - apart from interrupts, port behaves like a memory on the bus
module hbmsp_port
    import hbmsp_pkg::*;
#(
    parameter int DATA_W = HBMSP_DATA_W,
    parameter int ADDR_W = HBMSP_ADDR_W,
    parameter int REGS = HBMSP_REGS
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic host_type_select_hi,
    input wire logic host_type_select_lo,
    input wire logic chip_select_active_high,
    input wire logic chip_select_active_low_n,
    input wire logic [ADDR_W-1:0] host_address_bus,
    input wire logic [DATA_W-1:0] host_data_bus_in,
    output logic [DATA_W-1:0] host_data_bus_out,
    output logic host_data_bus_oe_n,
    input wire logic host_read_write_line,
    input wire logic host_data_strobe,
    input wire logic irq_a_req,
    input wire logic irq_b_req,
    output logic host_interrupt_a,
    output logic host_interrupt_b,
    output logic [DATA_W*REGS-1:0] reg_image,
    output logic [1:0] mode_active
);
    typedef struct packed {
        logic [DATA_W*REGS-1:0] mem;
        logic [DATA_W-1:0] dout;
        logic oe_n;
        logic wr_arm;
        logic [ADDR_W-1:0] wr_addr;
        logic [DATA_W-1:0] wr_data;
        logic irq_a;
        logic irq_b;
        hbmsp_mode_t mode;
    } hbmsp_state_t;

    hbmsp_state_t st;
    hbmsp_state_t next_st;

    logic ts_hi;
    logic ts_lo;
    logic cs_hi;
    logic cs_lo_n;
    logic rw;
    logic ds;
    logic [ADDR_W-1:0] addr_s;
    logic [DATA_W-1:0] data_s;
    logic sel;
    logic strobe_on;
    logic rd_access;
    logic wr_access;
    logic irq_pol_high;

    // every host pin crosses into mclk through the filtered synchroniser
    // reset levels match the idle pins, so no false access follows reset
    hbmsp_sync #(.RESET_LEVEL(1'b0)) u_ts_hi (
        .mclk(mclk),
        .rstn(rstn),
        .pin(host_type_select_hi),
        .level(ts_hi)
    );
    hbmsp_sync #(.RESET_LEVEL(1'b0)) u_ts_lo (
        .mclk(mclk),
        .rstn(rstn),
        .pin(host_type_select_lo),
        .level(ts_lo)
    );
    hbmsp_sync #(.RESET_LEVEL(1'b0)) u_cs_hi (
        .mclk(mclk),
        .rstn(rstn),
        .pin(chip_select_active_high),
        .level(cs_hi)
    );
    hbmsp_sync #(.RESET_LEVEL(1'b1)) u_cs_lo (
        .mclk(mclk),
        .rstn(rstn),
        .pin(chip_select_active_low_n),
        .level(cs_lo_n)
    );
    hbmsp_sync #(.RESET_LEVEL(1'b1)) u_rw (
        .mclk(mclk),
        .rstn(rstn),
        .pin(host_read_write_line),
        .level(rw)
    );
    hbmsp_sync #(.RESET_LEVEL(1'b1)) u_ds (
        .mclk(mclk),
        .rstn(rstn),
        .pin(host_data_strobe),
        .level(ds)
    );

    // address and data are held stable by the host around the strobe
    genvar gi;
    generate
        for (gi = 0; gi < ADDR_W; gi++) begin : g_addr
            hbmsp_sync #(.RESET_LEVEL(1'b0)) u_a (
                .mclk(mclk),
                .rstn(rstn),
                .pin(host_address_bus[gi]),
                .level(addr_s[gi])
            );
        end
        for (gi = 0; gi < DATA_W; gi++) begin : g_data
            hbmsp_sync #(.RESET_LEVEL(1'b0)) u_d (
                .mclk(mclk),
                .rstn(rstn),
                .pin(host_data_bus_in[gi]),
                .level(data_s[gi])
            );
        end
    endgenerate

    // decode of strobe meaning per mode
    always_comb begin
        sel = cs_hi && !cs_lo_n;
        strobe_on = 1'b0;
        rd_access = 1'b0;
        wr_access = 1'b0;
        irq_pol_high = 1'b0;
        case (st.mode)
            HBMSP_MODE_SPLIT: begin
                // strobe input is an active-low read, read/write pin an active-low write
                irq_pol_high = 1'b1;
                rd_access = sel && !ds;
                wr_access = sel && !rw;
                strobe_on = rd_access || wr_access;
            end
            HBMSP_MODE_FAM8: begin
                strobe_on = sel && ds;
                rd_access = strobe_on && rw;
                wr_access = strobe_on && !rw;
            end
            HBMSP_MODE_FAM16: begin
                strobe_on = sel && !ds;
                rd_access = strobe_on && rw;
                wr_access = strobe_on && !rw;
            end
            default: begin
                // reserved select: no access is decoded; interrupts stay active-low
                strobe_on = 1'b0;
            end
        endcase
    end

    // mode tracking, memory-like access and interrupt polarity
    always_comb begin
        next_st = st;
        case ({ts_hi, ts_lo})
            HBMSP_SEL_SPLIT: next_st.mode = HBMSP_MODE_SPLIT;
            HBMSP_SEL_FAM8: next_st.mode = HBMSP_MODE_FAM8;
            HBMSP_SEL_FAM16: next_st.mode = HBMSP_MODE_FAM16;
            default: next_st.mode = HBMSP_MODE_RSVD;
        endcase
        // capture during the strobe, commit at its trailing edge
        if (wr_access) begin
            next_st.wr_arm = 1'b1;
            next_st.wr_addr = addr_s;
            next_st.wr_data = data_s;
        end else if (st.wr_arm) begin
            next_st.wr_arm = 1'b0;
            next_st.mem[st.wr_addr*DATA_W +: DATA_W] = st.wr_data;
        end
        // drive read data only while a read is in progress
        if (rd_access && !wr_access) begin
            next_st.oe_n = 1'b0;
            next_st.dout = st.mem[addr_s*DATA_W +: DATA_W];
        end else begin
            next_st.oe_n = 1'b1;
            next_st.dout = HBMSP_REG_RESET;
        end
        // interrupt level follows the mode polarity
        next_st.irq_a = irq_pol_high ? irq_a_req : !irq_a_req;
        next_st.irq_b = irq_pol_high ? irq_b_req : !irq_b_req;
    end

    // reset puts interrupts inactive for the split mode selected by low pins
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st.mem <= {REGS{HBMSP_REG_RESET}};
            st.dout <= HBMSP_REG_RESET;
            st.oe_n <= 1'b1;
            st.wr_arm <= 1'b0;
            st.wr_addr <= '0;
            st.wr_data <= HBMSP_REG_RESET;
            st.irq_a <= 1'b0;
            st.irq_b <= 1'b0;
            st.mode <= HBMSP_MODE_SPLIT;
        end else begin
            st <= next_st;
        end
    end

    assign host_data_bus_out = st.dout;
    assign host_data_bus_oe_n = st.oe_n;
    assign host_interrupt_a = st.irq_a;
    assign host_interrupt_b = st.irq_b;
    assign reg_image = st.mem;
    assign mode_active = st.mode;
endmodule : hbmsp_port
`default_nettype wire

// file: bench/hbmsp_sva.sv
// Purpose: checks on the host port pins
// Assumes: host holds strobes 5+ mclk
// Notes: 7-8 cycle windows cover pin sync
`timescale 1ns/1ps
`default_nettype none
module hbmsp_sva (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic host_type_select_hi,
    input wire logic host_type_select_lo,
    input wire logic chip_select_active_high,
    input wire logic chip_select_active_low_n,
    input wire logic [7:0] host_data_bus_out,
    input wire logic host_data_bus_oe_n,
    input wire logic irq_a_req,
    input wire logic host_interrupt_a,
    input wire logic [255:0] reg_image,
    input wire logic [1:0] mode_active
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // irq copied in split mode, inverted in family modes
    chk_irq_pol: assert property ($stable(mode_active) && mode_active != 2'h3
        |-> host_interrupt_a == ($past(irq_a_req) ^ (mode_active != 2'h0))) else $error("irq");
    chk_bus_idle: assert property (host_data_bus_oe_n |-> host_data_bus_out == 8'h00)
        else $error("bus");
    chk_drive_len: assert property ($fell(host_data_bus_oe_n) |-> !host_data_bus_oe_n [*4])
        else $error("len");
    // a lost select stops both the drive and the writes
    chk_csh_gate: assert property (!chip_select_active_high [*7] |-> host_data_bus_oe_n)
        else $error("csh");
    chk_csl_gate: assert property (chip_select_active_low_n [*7] |-> host_data_bus_oe_n)
        else $error("csl");
    chk_reg_csh: assert property (!chip_select_active_high [*8] |=> $stable(reg_image))
        else $error("regh");
    chk_reg_csl: assert property (chip_select_active_low_n [*8] |=> $stable(reg_image))
        else $error("regl");
    chk_mode_sel: assert property ($stable({host_type_select_hi, host_type_select_lo}) [*8]
        |-> mode_active == {host_type_select_hi, host_type_select_lo}) else $error("mode");
endmodule : hbmsp_sva
bind hbmsp_port hbmsp_sva i_sva (.mclk, .rstn, .host_type_select_hi, .host_type_select_lo,
    .chip_select_active_high, .chip_select_active_low_n, .host_data_bus_out,
    .host_data_bus_oe_n, .irq_a_req, .host_interrupt_a, .reg_image, .mode_active);
`default_nettype wire

// file: bench/hbmsp_host.sv
// Purpose: host processor on the port pins
// Assumes: one access at a time
// Notes: idle data shows the inverted last value
`timescale 1ns/1ps
`default_nettype none
module hbmsp_host (
    input wire logic mclk,
    input wire logic [7:0] dout,
    input wire logic oe_n,
    output logic [1:0] sel,
    output logic cs_h,
    output logic cs_l_n,
    output logic [4:0] addr,
    output logic [7:0] bus,
    output logic rw,
    output logic ds
);
    logic [7:0] drv = 8'h5a;
    logic [1:0] m = 2'h0;
    // pad level: the port wins while it drives
    assign bus = oe_n ? drv : dout;
    initial {sel, cs_h, cs_l_n, addr, rw, ds} = 11'h083;
    // mode pins; idle strobe level follows the mode
    task automatic set_mode(input logic [1:0] md);
        m = md;
        @(posedge mclk);
        sel <= md;
        ds <= (md != 2'h1);
        repeat (8) @(posedge mclk);
    endtask : set_mode
    // one access; strobe held 8 mclk so the sync chain sees it
    task automatic access(input logic w, input logic [1:0] cs, input logic [4:0] a,
            input logic [7:0] d, output logic [8:0] q);
        @(posedge mclk);
        {cs_h, cs_l_n, addr} <= {cs, a};
        drv <= w ? d : ~drv;
        rw <= !w;
        ds <= (m == 2'h0) ? w : (m == 2'h1);
        repeat (8) @(posedge mclk);
        q = {oe_n, dout};
        rw <= 1'b1;
        ds <= (m != 2'h1);
        repeat (2) @(posedge mclk);
        cs_h <= 1'b0;
        cs_l_n <= 1'b1;
        drv <= ~drv;
        repeat (8) @(posedge mclk);
    endtask : access
endmodule : hbmsp_host
`default_nettype wire

// file: bench/hbmsp_port_tb_top.sv
// Purpose: bench of the host port
// Assumes: host model keeps pin timing
// Notes: values worked out per mode
`timescale 1ns/1ps
`default_nettype none
module hbmsp_port_tb_top
    import hbmsp_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic irq_a = 1'b0;
    logic irq_b = 1'b0;
    logic cs_h, cs_l_n, rw, ds, oe_n, int_a, int_b;
    logic [1:0] sel, mode;
    logic [4:0] addr;
    logic [7:0] bus, dout;
    logic [8:0] q;
    logic [255:0] img;
    int miscompares = 0;
    int samples_checked = 0;
    hbmsp_port i_dut (.mclk, .rstn, .host_type_select_hi(sel[1]), .host_type_select_lo(sel[0]),
        .chip_select_active_high(cs_h), .chip_select_active_low_n(cs_l_n),
        .host_address_bus(addr), .host_data_bus_in(bus), .host_data_bus_out(dout),
        .host_data_bus_oe_n(oe_n), .host_read_write_line(rw), .host_data_strobe(ds),
        .irq_a_req(irq_a), .irq_b_req(irq_b), .host_interrupt_a(int_a),
        .host_interrupt_b(int_b), .reg_image(img), .mode_active(mode));
    hbmsp_host i_host (.mclk, .dout, .oe_n, .sel, .cs_h, .cs_l_n, .addr, .bus, .rw, .ds);
    // 200 MHz clock
    initial forever #2.5 mclk = ~mclk;
    task automatic cmp(input string s, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask : cmp
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // each non-reserved mode: write, read back, image and irq polarity
    task automatic t_modes();
        for (int k = 0; k < 3; k++) begin
            i_host.set_mode(2'(k));
            cmp("mode", 8'(k), 8'(mode));
            i_host.access(1'b1, 2'h2, 5'(k * 15 + 1), 8'(k * 16 + 10), q);
            cmp("img", 8'(k * 16 + 10), img[8 * (k * 15 + 1) +: 8]);
            i_host.access(1'b0, 2'h2, 5'(k * 15 + 1), 8'h00, q);
            cmp("rd", 8'(k * 16 + 10), q[7:0]);
            cmp("oe", 8'h00, 8'(q[8]));
            irq_a <= 1'b1;
            repeat (3) @(posedge mclk);
            cmp("int", (2'(k) == HBMSP_SEL_SPLIT) ? 8'h02 : 8'h01,
                {6'h0, int_a, int_b});
            irq_a <= 1'b0;
        end
        $display("test modes done");
    endtask : t_modes
    // half-selected accesses must neither write nor drive
    task automatic t_select();
        i_host.access(1'b1, 2'h0, 5'h1f, 8'hd5, q);
        i_host.access(1'b1, 2'h3, 5'h1f, 8'hd5, q);
        cmp("held", 8'h2a, img[255:248]);
        i_host.access(1'b0, 2'h0, 5'h1f, 8'h00, q);
        cmp("nodrv", 8'h01, 8'(q[8]));
        $display("test select done");
    endtask : t_select
    initial begin
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        t_modes();
        t_select();
        end_sim();
    end
    // watchdog, run needs about 210 cycles
    initial begin
        repeat (2000) @(posedge mclk);
        miscompares++;
        end_sim();
    end
endmodule : hbmsp_port_tb_top
`default_nettype wire
